// ==== verilog/pwo_pkg.sv ====
package pwo_pkg;

  // ************************************************************
  // Widths, limits and timing
  // ************************************************************
  localparam int LVL_W = 10;
  localparam logic [LVL_W-1:0] LVL_MAX = 10'h3ff;
  localparam logic [LVL_W-1:0] LVL_RST = 10'h000;
  localparam int ADDR_W = 16;
  localparam logic [ADDR_W-1:0] ADDR_ANY = 16'hffff;
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'hffff;
  localparam int PT_W = 8;
  localparam logic [PT_W-1:0] PT_RST = 8'hff;
  localparam logic [PT_W-1:0] PT_NONE = 8'h00;
  localparam int CLK_NS = 50;
  localparam int PERIOD_NS = 64000;
  localparam int PERIOD_CYC = PERIOD_NS / CLK_NS;
  localparam int CNT_W = $clog2(PERIOD_CYC);
  localparam int TICK_MS = 100;
  localparam int TICK_CYC = TICK_MS * 1000000 / CLK_NS;
  localparam int STEPS = 1023;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    PWO_FN_OFF,
    PWO_FN_RSSI,
    PWO_FN_DIRECT
  } pwo_fn_e;

  typedef enum logic [2:0] {
    PWO_SEL_LVL0,
    PWO_SEL_LVL1,
    PWO_SEL_FN0,
    PWO_SEL_FN1,
    PWO_SEL_ADDR,
    PWO_SEL_PT
  } pwo_sel_e;

  typedef struct packed {
    pwo_fn_e first_output_function;
    pwo_fn_e second_output_function;
    logic [LVL_W-1:0] first_level_setting;
    logic [LVL_W-1:0] second_level_setting;
    logic [ADDR_W-1:0] bound_input_source_address;
    logic [PT_W-1:0] passthrough_hold_timeout;
  } pwo_cfg_s;

  typedef struct packed {
    logic [ADDR_W-1:0] src;
    logic [LVL_W-1:0] analog_channel_zero;
    logic [LVL_W-1:0] analog_channel_one;
  } pwo_smp_s;

endpackage

// ==== verilog/pwo_chan.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwo_chan
  import pwo_pkg::*;
#(
  parameter int PERIOD = PERIOD_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire pwo_fn_e fn_in,
  input wire logic [LVL_W-1:0] cfg_lvl_in,
  input wire logic [LVL_W-1:0] rssi_lvl_in,
  input wire logic apply_in,
  input wire logic smp_load_in,
  input wire logic [LVL_W-1:0] smp_val_in,
  input wire logic tick_in,
  input wire logic [PT_W-1:0] pt_in,
  output logic pulse_out
);

  localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD - 1);

  function automatic logic [31:0] scale(input logic [31:0] a,
                                        input logic [31:0] b);
    return a * b;
  endfunction

  logic [LVL_W-1:0] live_r;
  logic passed_r;
  logic [PT_W-1:0] tmo_r;
  logic [CNT_W-1:0] cnt_r;
  logic [LVL_W-1:0] duty_r;
  logic [LVL_W-1:0] duty_nxt;
  logic expire;

  // ************************************************************
  // Live level: host setting, passed sample, hold timeout
  // ************************************************************
  // The timeout only governs a level that arrived as a sample; a host
  // level stays until the host or a passed sample replaces it. Counting up to the setting,
  // not matching it, ends the hold even if the setting is lowered mid-count.
  assign expire = passed_r && live_r != LVL_RST && pt_in != PT_NONE &&
                  tick_in && (tmo_r + 8'h01) >= pt_in;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      live_r <= LVL_RST;
      passed_r <= 1'b0;
    end else if (smp_load_in) begin
      live_r <= smp_val_in;
      passed_r <= 1'b1;
    end else if (apply_in) begin
      live_r <= cfg_lvl_in;
      passed_r <= 1'b0;
    end else if (expire) begin
      live_r <= LVL_RST;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in || smp_load_in || apply_in) begin
      tmo_r <= PT_NONE;
    end else if (tick_in && passed_r && live_r != LVL_RST) begin
      tmo_r <= expire ? PT_NONE : tmo_r + 8'h01;
    end
  end

  // ************************************************************
  // Period counter and pulse
  // ************************************************************
  always_comb begin
    case (fn_in)
      PWO_FN_RSSI: duty_nxt = rssi_lvl_in;
      PWO_FN_DIRECT: duty_nxt = live_r;
      default: duty_nxt = LVL_RST;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cnt_r <= '0;
      duty_r <= LVL_RST;
    end else if (cnt_r == LAST) begin
      cnt_r <= '0;
      duty_r <= duty_nxt;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Comparing scaled products keeps 1023 steps exact in a 1280-cycle period.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= scale(32'(cnt_r), STEPS) <
                   scale(32'(duty_r), PERIOD);
    end
  end

  AST_DUTY_ZERO: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    (duty_r == LVL_RST && cnt_r != LAST) |=> !pulse_out)
    else $error("zero level produced a high pulse");
  AST_DUTY_FULL: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    (duty_r == LVL_MAX && cnt_r != LAST) |=> pulse_out)
    else $error("full level produced a low pulse");
  AST_CNT_WRAP: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    cnt_r == LAST |=> cnt_r == '0)
    else $error("period length wrong");
  AST_CNT_STEP: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    cnt_r != LAST |=> cnt_r == $past(cnt_r) + 1'b1)
    else $error("period counter skipped a step");
  AST_DUTY_HOLD: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    cnt_r != LAST |=> $stable(duty_r))
    else $error("duty changed inside a period");
  AST_SMP_LOAD: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    smp_load_in |=> live_r == $past(smp_val_in) && passed_r)
    else $error("sample not loaded");
  AST_APPLY: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    (apply_in && !smp_load_in) |=> live_r == $past(cfg_lvl_in) && !passed_r)
    else $error("applied level not loaded");
  AST_EXPIRE: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    (expire && !smp_load_in && !apply_in) |=> live_r == LVL_RST)
    else $error("timeout did not clear level");

endmodule
`default_nettype wire

// ==== verilog/pwo_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwo_top
  import pwo_pkg::*;
#(
  parameter int TICK = TICK_CYC,
  parameter int PERIOD = PERIOD_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic cfg_wr_in,
  input wire pwo_sel_e cfg_sel_in,
  input wire logic [ADDR_W-1:0] cfg_data_in,
  input wire logic apply_changes_action_in,
  input wire logic leave_command_mode_action_in,
  input wire logic sample_valid_in,
  input wire pwo_smp_s sample_in,
  input wire logic [LVL_W-1:0] rssi_level_in,
  output pwo_cfg_s cfg_out,
  output logic first_pulse_output_out,
  output logic second_pulse_output_out
);

  pwo_cfg_s cfg_r;
  pwo_fn_e fn0_r;
  pwo_fn_e fn1_r;
  localparam int DIV_W = $clog2(TICK);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK - 1);

  logic [DIV_W-1:0] div_r;
  logic tick;
  logic apply;
  logic smp_ok;

  // ************************************************************
  // Shared decoders
  // ************************************************************
  // The whole data word is compared, so a large code whose low bits look
  // legal is still refused.
  function automatic logic fn_code_ok(input logic [ADDR_W-1:0] d);
    return d <= ADDR_W'(PWO_FN_DIRECT);
  endfunction

  // The all-ones binding is a wildcard that takes any sender.
  function automatic logic src_match(input logic [ADDR_W-1:0] bound,
                                     input logic [ADDR_W-1:0] src);
    return bound == ADDR_ANY || bound == src;
  endfunction

  // ************************************************************
  // Stored settings, written by the host
  // ************************************************************
  // Function codes above direct are dropped so the selector never holds
  // an undefined mode.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cfg_r.first_output_function <= PWO_FN_RSSI;
      cfg_r.second_output_function <= PWO_FN_OFF;
      cfg_r.first_level_setting <= LVL_RST;
      cfg_r.second_level_setting <= LVL_RST;
      cfg_r.bound_input_source_address <= ADDR_RST;
      cfg_r.passthrough_hold_timeout <= PT_RST;
    end else if (cfg_wr_in) begin
      case (cfg_sel_in)
        PWO_SEL_LVL0: cfg_r.first_level_setting <= cfg_data_in[LVL_W-1:0];
        PWO_SEL_LVL1: begin
          cfg_r.second_level_setting <= cfg_data_in[LVL_W-1:0];
        end
        PWO_SEL_FN0: begin
          if (fn_code_ok(cfg_data_in)) begin
            cfg_r.first_output_function <= pwo_fn_e'(cfg_data_in[1:0]);
          end
        end
        PWO_SEL_FN1: begin
          if (fn_code_ok(cfg_data_in)) begin
            cfg_r.second_output_function <= pwo_fn_e'(cfg_data_in[1:0]);
          end
        end
        PWO_SEL_ADDR: cfg_r.bound_input_source_address <= cfg_data_in;
        PWO_SEL_PT: cfg_r.passthrough_hold_timeout <= cfg_data_in[PT_W-1:0];
        default: ;
      endcase
    end
  end

  assign cfg_out = cfg_r;

  // ************************************************************
  // Applied functions and sample acceptance
  // ************************************************************
  assign apply = apply_changes_action_in || leave_command_mode_action_in;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      fn0_r <= PWO_FN_RSSI;
      fn1_r <= PWO_FN_OFF;
    end else if (apply) begin
      fn0_r <= cfg_r.first_output_function;
      fn1_r <= cfg_r.second_output_function;
    end
  end

  assign smp_ok = sample_valid_in &&
    src_match(cfg_r.bound_input_source_address, sample_in.src);

  // ************************************************************
  // Timeout tick divider
  // ************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || tick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  assign tick = div_r == DIV_LAST;

  pwo_chan #(.PERIOD(PERIOD)) u_chan0 (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .fn_in(fn0_r),
    .cfg_lvl_in(cfg_r.first_level_setting),
    .rssi_lvl_in(rssi_level_in),
    .apply_in(apply),
    .smp_load_in(smp_ok),
    .smp_val_in(sample_in.analog_channel_zero),
    .tick_in(tick),
    .pt_in(cfg_r.passthrough_hold_timeout),
    .pulse_out(first_pulse_output_out)
  );

  pwo_chan #(.PERIOD(PERIOD)) u_chan1 (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .fn_in(fn1_r),
    .cfg_lvl_in(cfg_r.second_level_setting),
    .rssi_lvl_in(rssi_level_in),
    .apply_in(apply),
    .smp_load_in(smp_ok),
    .smp_val_in(sample_in.analog_channel_one),
    .tick_in(tick),
    .pt_in(cfg_r.passthrough_hold_timeout),
    .pulse_out(second_pulse_output_out)
  );

  // ************************************************************
  // Checks on settings, applied functions, sample routing and the tick divider
  // ************************************************************
  AST_RESET_FN: assert property (@(posedge sys_clk_in)
    $past(rst_in) |-> cfg_r.first_output_function == PWO_FN_RSSI &&
      cfg_r.second_output_function == PWO_FN_OFF &&
      cfg_r.second_level_setting == LVL_RST)
    else $error("reset values wrong");
  // A refused sample may coincide with an expiring hold timer, so a level
  // that drops to zero is allowed here.
  AST_ADDR_FILTER: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    (sample_valid_in && !apply &&
     cfg_r.bound_input_source_address != ADDR_ANY &&
     cfg_r.bound_input_source_address != sample_in.src) |=>
      (u_chan0.live_r == $past(u_chan0.live_r) ||
       u_chan0.live_r == LVL_RST) &&
      (u_chan1.live_r == $past(u_chan1.live_r) ||
       u_chan1.live_r == LVL_RST))
    else $error("sample from foreign source accepted");
  AST_LVL1_WR: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    (cfg_wr_in && cfg_sel_in == PWO_SEL_LVL1) |=>
      cfg_r.second_level_setting == $past(cfg_data_in[LVL_W-1:0]))
    else $error("second level not stored");
  AST_FN_APPLY: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    (apply && !cfg_wr_in) |=> fn1_r == cfg_r.second_output_function)
    else $error("function not applied");
  AST_FN0_APPLY: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    (apply && !cfg_wr_in) |=> fn0_r == cfg_r.first_output_function)
    else $error("first function not applied");
  AST_FN_HOLD: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    !apply |=> $stable(fn0_r) && $stable(fn1_r))
    else $error("function changed without an apply");
  AST_FN0_WR: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    (cfg_wr_in && cfg_sel_in == PWO_SEL_FN0 &&
     cfg_data_in <= ADDR_W'(PWO_FN_DIRECT)) |=>
      cfg_r.first_output_function == pwo_fn_e'($past(cfg_data_in[1:0])))
    else $error("first function not stored");
  AST_FN0_REFUSE: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    (cfg_wr_in && cfg_sel_in == PWO_SEL_FN0 &&
     cfg_data_in > ADDR_W'(PWO_FN_DIRECT)) |=>
      $stable(cfg_r.first_output_function))
    else $error("out of range first function stored");
  AST_FN1_REFUSE: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    (cfg_wr_in && cfg_sel_in == PWO_SEL_FN1 &&
     cfg_data_in > ADDR_W'(PWO_FN_DIRECT)) |=>
      $stable(cfg_r.second_output_function))
    else $error("out of range second function stored");
  AST_SMP_ROUTE: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    smp_ok |=> u_chan0.live_r == $past(sample_in.analog_channel_zero) &&
      u_chan1.live_r == $past(sample_in.analog_channel_one))
    else $error("sample channels reached the wrong output");
  AST_TICK_WRAP: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    tick |=> div_r == '0)
    else $error("timeout divider did not restart");
  AST_DIV_RANGE: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    div_r <= DIV_LAST)
    else $error("timeout divider overran");

endmodule
`default_nettype wire

// ==== testbench/pwo_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwo_host_model
  import pwo_pkg::*;
(
  input wire logic sys_clk_in,
  output logic cfg_wr_out,
  output pwo_sel_e cfg_sel_out,
  output logic [ADDR_W-1:0] cfg_data_out,
  output logic apply_out,
  output logic leave_out,
  output logic smp_valid_out,
  output pwo_smp_s smp_out
);
  initial begin
    cfg_wr_out = 1'b0;
    cfg_sel_out = PWO_SEL_LVL0;
    cfg_data_out = 16'h0000;
    apply_out = 1'b0;
    leave_out = 1'b0;
    smp_valid_out = 1'b0;
    smp_out = '0;
  end
  // Released data is inverted so a stale value can never look valid.
  task automatic put(input pwo_sel_e sel, input logic [ADDR_W-1:0] d);
    @(posedge sys_clk_in);
    cfg_wr_out <= 1'b1;
    cfg_sel_out <= sel;
    cfg_data_out <= d;
    @(posedge sys_clk_in);
    cfg_wr_out <= 1'b0;
    cfg_data_out <= ~d;
  endtask
  // Written levels and functions reach the lines only after one of these actions.
  task automatic commit(input logic leave);
    @(posedge sys_clk_in);
    apply_out <= ~leave;
    leave_out <= leave;
    @(posedge sys_clk_in);
    apply_out <= 1'b0;
    leave_out <= 1'b0;
  endtask
  task automatic send(input pwo_smp_s s);
    @(posedge sys_clk_in);
    smp_valid_out <= 1'b1;
    smp_out <= s;
    @(posedge sys_clk_in);
    smp_valid_out <= 1'b0;
    smp_out <= ~s;
  endtask
endmodule
`default_nettype wire

// ==== testbench/test_pwo_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_pwo_top
  import pwo_pkg::*;
;
  localparam int P = 40;
  logic clk, rst, wr, ap, lv, sv, p0, p1;
  pwo_sel_e sel;
  logic [ADDR_W-1:0] dat;
  pwo_smp_s smp;
  logic [LVL_W-1:0] rssi;
  pwo_cfg_s cfg;
  logic [31:0] n;
  int n_errors = 0;
  int checks_done = 0;
  // ************************************************************
  // Clock, units and helpers
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  pwo_host_model host_u (.sys_clk_in(clk), .cfg_wr_out(wr),
    .cfg_sel_out(sel), .cfg_data_out(dat), .apply_out(ap), .leave_out(lv),
    .smp_valid_out(sv), .smp_out(smp));
  pwo_top #(.TICK(20), .PERIOD(P)) dut_u (.sys_clk_in(clk), .rst_in(rst),
    .cfg_wr_in(wr), .cfg_sel_in(sel), .cfg_data_in(dat),
    .apply_changes_action_in(ap), .leave_command_mode_action_in(lv),
    .sample_valid_in(sv), .sample_in(smp), .rssi_level_in(rssi),
    .cfg_out(cfg), .first_pulse_output_out(p0),
    .second_pulse_output_out(p1));
  task automatic conclude();
    if (n_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Two full periods let a new level pass the period boundary first.
  task automatic duty(input logic second);
    repeat (2 * P + 4) @(posedge clk);
    n = 0;
    repeat (P) begin
      @(negedge clk);
      if ((second ? p1 : p0) === 1'b1) n++;
    end
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    conclude();
  end
  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    rst = 1'b1;
    rssi = 10'h000;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("fn0", 32'(cfg.first_output_function), 32'(PWO_FN_RSSI));
    check("fn1", 32'(cfg.second_output_function), 32'(PWO_FN_OFF));
    check("lvl1", 32'(cfg.second_level_setting), 32'h0);
    check("addr", 32'(cfg.bound_input_source_address), 32'hffff);
    check("pt", 32'(cfg.passthrough_hold_timeout), 32'hff);
    host_u.put(PWO_SEL_LVL1, 16'h03ff);
    @(posedge clk);
    check("lvl1", 32'(cfg.second_level_setting), 32'h3ff);
    host_u.put(PWO_SEL_FN1, 16'h0002);
    duty(1'b1);
    check("out1 unapplied", n, 32'd0);
    host_u.commit(1'b0);
    duty(1'b1);
    check("out1 full", n, 32'(P));
    host_u.put(PWO_SEL_LVL1, 16'h01ff);
    host_u.commit(1'b1);
    duty(1'b1);
    check("out1 half", n, 32'd20);
    rssi <= 10'h3ff;
    duty(1'b0);
    check("out0 rssi", n, 32'(P));
    host_u.put(PWO_SEL_FN0, 16'h0003);
    @(posedge clk);
    check("fn0 bad", 32'(cfg.first_output_function), 32'h1);
    host_u.put(PWO_SEL_FN1, 16'h0003);
    @(posedge clk);
    check("fn1 bad", 32'(cfg.second_output_function), 32'h2);
    host_u.put(PWO_SEL_FN0, 16'h0000);
    host_u.commit(1'b0);
    duty(1'b0);
    check("out0 off", n, 32'd0);
    host_u.put(PWO_SEL_FN0, 16'h0002);
    host_u.put(PWO_SEL_LVL0, 16'h0155);
    @(posedge clk);
    check("lvl0", 32'(cfg.first_level_setting), 32'h155);
    host_u.put(PWO_SEL_ADDR, 16'h1234);
    host_u.commit(1'b0);
    host_u.send({16'h5555, 10'h3ff, 10'h3ff});
    duty(1'b0);
    check("out0 foreign", n, 32'd14);
    host_u.send({16'h1234, 10'h3ff, 10'h000});
    duty(1'b0);
    check("out0 passed", n, 32'(P));
    check("out1 passed", 32'(p1), 32'h0);
    host_u.put(PWO_SEL_PT, 16'h0008);
    host_u.send({16'h1234, 10'h3ff, 10'h3ff});
    duty(1'b1);
    check("out1 passed", n, 32'(P));
    repeat (200) @(posedge clk);
    duty(1'b1);
    check("out1 expired", n, 32'd0);
    host_u.put(PWO_SEL_ADDR, ADDR_ANY);
    host_u.send({16'h5555, 10'h000, 10'h3ff});
    duty(1'b1);
    check("out1 any source", n, 32'(P));
    conclude();
  end
endmodule
`default_nettype wire
